// *** dtb_timer.sv ***
// dual 16-bit timer with buffer pairing, sync and complementary pwm
// Function
// - buffer-d bit set pairs B with D as buffer; clear leaves D ordinary
// - buffer-c bit set pairs A with C as buffer; clear leaves C ordinary
// - reserved mode bits 3..1 read one, writes ignored
// - sync bit makes preset or clear of either counter hit both
// - complementary pwm turns B0..D0 and A1..D1 into pwm outputs
// - cycle register holds period; B0, A1, B1 hold change points
// - output enable register drives or suppresses each timer pin
// - setting both run bits starts both counters
// - buffer pairs are A with C and B with D
// - buffer transfer differs for capture, compare, reset pwm, comp pwm
// - shared pin: port input/output by direction, or timer output
// - standby bit puts the whole timer unit in standby
// - compare match with buffering copies buffer into general register
// - capture with buffering moves old value to buffer, counter in
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
module dtb_timer #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // timer pins, index 4*channel + {A,B,C,D}; pin 7 shared with port
  input wire logic [7:0] tio_in,
  output logic [7:0] tio_out,
  output logic [7:0] tio_oe_n,
  input wire logic ext_clk_in
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [3:0] mode_buf_q;
  logic sync_q;
  logic [1:0] run_q;
  logic [1:0] combo_q;
  logic pwmd_q;
  logic [7:0] outctl_q;
  logic [7:0] outdis_q;
  logic [6:0] ctl_q [2];
  logic [11:0] io_q [2];
  logic pdir_q;
  logic pdat_q;
  logic stby_q;
  logic [CNT_W-1:0] cnt_q [2];
  logic [CNT_W-1:0] gr_q [8];
  logic [7:0] lvl_q;
  logic [7:0] out_q;
  logic [7:0] oe_n_q;
  logic [2:0] psc_q;
  logic [8:0] s1_q, s2_q, s3_q, filt_q, prev_q;

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic [7:0] waddr_q, raddr_unused;
  logic [31:0] wdata_q, rdata_q, rd_d;
  logic [3:0] wstrb_q;
  logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
  logic awready_q, wready_q, arready_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_err, rd_err;

  wire aw_take = s_axi_awvalid & awready_q;
  wire w_take = s_axi_wvalid & wready_q;
  wire ar_take = s_axi_arvalid & arready_q;
  wire do_wr = aw_full_q & w_full_q & ~bvalid_q;
  wire aw_full_d = (aw_full_q | aw_take) & ~do_wr;
  wire w_full_d = (w_full_q | w_take) & ~do_wr;
  wire bvalid_d = do_wr | (bvalid_q & ~s_axi_bready);
  wire rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                       {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  // byte-lane merge so a partial write keeps untouched lanes
  wire [31:0] wset = wdata_q & wmask;

  // handshake flops; one write and one read in flight at most
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
      bresp_q <= dtb_pkg::RESP_OKAY;
      rresp_q <= dtb_pkg::RESP_OKAY;
      rdata_q <= 32'h0;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      bvalid_q <= bvalid_d;
      rvalid_q <= rvalid_d;
      awready_q <= ~aw_full_d & ~bvalid_d;
      wready_q <= ~w_full_d & ~bvalid_d;
      arready_q <= ~rvalid_d;
      if (aw_take) waddr_q <= s_axi_awaddr;
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr)
        bresp_q <= wr_err ? dtb_pkg::RESP_SLVERR : dtb_pkg::RESP_OKAY;
      if (ar_take) begin
        rdata_q <= rd_d;
        rresp_q <= rd_err ? dtb_pkg::RESP_SLVERR : dtb_pkg::RESP_OKAY;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign raddr_unused = {2'b00, s_axi_awprot, s_axi_arprot};

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  wire wr_mode = do_wr && waddr_q == dtb_pkg::OFS_MODE;
  wire wr_run = do_wr && waddr_q == dtb_pkg::OFS_RUN;
  wire wr_func = do_wr && waddr_q == dtb_pkg::OFS_FUNC;
  wire wr_outctl = do_wr && waddr_q == dtb_pkg::OFS_OUTCTL;
  wire wr_outen = do_wr && waddr_q == dtb_pkg::OFS_OUTEN;
  wire wr_ctl0 = do_wr && waddr_q == dtb_pkg::OFS_CTL0;
  wire wr_ctl1 = do_wr && waddr_q == dtb_pkg::OFS_CTL1;
  wire wr_io0 = do_wr && waddr_q == dtb_pkg::OFS_IO0;
  wire wr_io1 = do_wr && waddr_q == dtb_pkg::OFS_IO1;
  wire wr_port = do_wr && waddr_q == dtb_pkg::OFS_PORT;
  wire wr_stby = do_wr && waddr_q == dtb_pkg::OFS_STBY;
  wire wr_cnt0 = do_wr && waddr_q == dtb_pkg::OFS_CNT0;
  wire wr_cnt1 = do_wr && waddr_q == dtb_pkg::OFS_CNT1;
  wire wr_grs = waddr_q >= dtb_pkg::OFS_GR && waddr_q < dtb_pkg::OFS_GR_END;
  assign wr_err = !(wr_grs || waddr_q <= dtb_pkg::OFS_CNT1) ||
                  waddr_q[1:0] != 2'b00;
  wire [31:0] wm_mode = {24'h0, mode_buf_q, 3'h0, sync_q} & ~wmask | wset;
  wire [31:0] wm_cnt = {16'h0, cnt_q[wr_cnt1]} & ~wmask | wset;
  wire [31:0] wm_io = {20'h0, io_q[wr_io1]} & ~wmask | wset;

  // control registers; reserved mode bits are not stored at all
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_buf_q <= 4'h0;
      sync_q <= 1'b0;
      run_q <= 2'b00;
      combo_q <= dtb_pkg::COMBO_NORMAL;
      pwmd_q <= 1'b0;
      outdis_q <= dtb_pkg::RST_OUTDIS;
      ctl_q[0] <= 7'h00;
      ctl_q[1] <= 7'h00;
      io_q[0] <= 12'h000;
      io_q[1] <= 12'h000;
      pdir_q <= 1'b0;
      pdat_q <= 1'b0;
      stby_q <= 1'b0;
    end else begin
      if (wr_mode) begin
        mode_buf_q <= wm_mode[7:4];
        sync_q <= wm_mode[dtb_pkg::MODE_SYNC_BIT];
      end
      if (wr_run && wstrb_q[0]) run_q <= wdata_q[1:0];
      if (wr_func && wstrb_q[0]) begin
        combo_q <= wdata_q[1:0];
        pwmd_q <= wdata_q[dtb_pkg::FUNC_PWMD_BIT];
      end
      if (wr_outen && wstrb_q[0]) outdis_q <= wdata_q[7:0];
      if (wr_ctl0 && wstrb_q[0]) ctl_q[0] <= wdata_q[6:0];
      if (wr_ctl1 && wstrb_q[0]) ctl_q[1] <= wdata_q[6:0];
      if (wr_io0) io_q[0] <= wm_io[11:0];
      if (wr_io1) io_q[1] <= wm_io[11:0];
      if (wr_port && wstrb_q[0]) {pdat_q, pdir_q} <= wdata_q[1:0];
      if (wr_stby && wstrb_q[0]) stby_q <= wdata_q[0];
    end
  end

  // ----------------------------------------------------------------
  // pin input filtering and prescaler
  // ----------------------------------------------------------------
  wire [8:0] filt_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
  wire [8:0] rise = filt_q & ~prev_q;
  wire [8:0] fall = ~filt_q & prev_q;

  // three stages; a level counts only once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {s1_q, s2_q, s3_q} <= 27'h0;
      filt_q <= 9'h000;
      prev_q <= 9'h000;
      psc_q <= 3'h0;
    end else begin
      s1_q <= {ext_clk_in, tio_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
      prev_q <= filt_q;
      psc_q <= stby_q ? 3'h0 : psc_q + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // per-channel clocking and counters
  // ----------------------------------------------------------------
  logic [1:0] adv, clr_own, clr;
  logic [7:0] match_ev, cap;
  wire comp = combo_q == dtb_pkg::COMBO_COMP;
  wire pend = cnt_q[0] == gr_q[0] && adv[0];

  genvar c, e;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      wire [2:0] psel = ctl_q[c][dtb_pkg::CTL_PSC_LSB +: 3];
      wire [1:0] esel = ctl_q[c][dtb_pkg::CTL_EDGE_LSB +: 2];
      wire [1:0] csel = ctl_q[c][dtb_pkg::CTL_CLR_LSB +: 2];
      wire ext_tick = esel == 2'b00 ? rise[8] :
                      esel == 2'b01 ? fall[8] : (rise[8] | fall[8]);
      wire tick = psel == 3'd0 ? 1'b1 : psel == 3'd1 ? psc_q[0] :
                  psel == 3'd2 ? &psc_q[1:0] :
                  psel == 3'd3 ? &psc_q : ext_tick;
      wire wr_own = c == 0 ? wr_cnt0 : wr_cnt1;
      wire wr_oth = c == 0 ? wr_cnt1 : wr_cnt0;
      assign adv[c] = run_q[c] & tick & ~stby_q;
      assign clr_own[c] = csel == dtb_pkg::CLR_GRA ? match_ev[4*c] :
                          csel == dtb_pkg::CLR_GRB ? match_ev[4*c+1] : 1'b0;
      // clear source ignored in comp pwm; the cycle register wraps both
      assign clr[c] = comp ? pend :
                      clr_own[c] | (sync_q & clr_own[1-c]);

      // bus preset reaches both counters when synchronised
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cnt_q[c] <= '0;
        end else if (wr_own || (sync_q && wr_oth)) begin
          cnt_q[c] <= wm_cnt[CNT_W-1:0];
        end else if (clr[c]) begin
          cnt_q[c] <= '0;
        end else if (adv[c]) begin
          cnt_q[c] <= cnt_q[c] + 1'b1;
        end
      end
    end

    // --------------------------------------------------------------
    // general registers, buffers, compare and capture events
    // --------------------------------------------------------------
    for (e = 0; e < 8; e++) begin : g_gr
      localparam int CH = e / 4;
      localparam int K = e % 4;
      wire [2:0] iof = io_q[CH][3*K +: 3];
      wire bufen = mode_buf_q[2*CH + (K % 2)];
      wire wr_me = do_wr && waddr_q == dtb_pkg::OFS_GR + 8'(4*e);
      wire [31:0] wm_gr = {16'h0, gr_q[e]} & ~wmask | wset;
      // transfer moment depends on the mode the pair is used in
      wire xfer = comp ? pend :
                  combo_q == dtb_pkg::COMBO_RSYNC ? clr[0] :
                  match_ev[e];
      assign match_ev[e] = cnt_q[CH] == gr_q[e] && adv[CH];
      assign cap[e] = rise[e] & iof[2] & ~stby_q;

      if (K < 2) begin : g_main
        always_ff @(posedge aclk) begin
          if (!aresetn) begin
            gr_q[e] <= '1;
          end else if (wr_me) begin
            gr_q[e] <= wm_gr[CNT_W-1:0];
          end else if (cap[e]) begin
            gr_q[e] <= cnt_q[CH];
          end else if (bufen && !iof[2] && xfer) begin
            gr_q[e] <= gr_q[e+2];
          end
        end
      end else begin : g_buf
        always_ff @(posedge aclk) begin
          if (!aresetn) begin
            gr_q[e] <= '1;
          end else if (wr_me) begin
            gr_q[e] <= wm_gr[CNT_W-1:0];
          end else if (bufen && cap[e-2]) begin
            gr_q[e] <= gr_q[e-2];
          end else if (!bufen && cap[e]) begin
            gr_q[e] <= cnt_q[CH];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // pwm levels and pin ownership
  // ----------------------------------------------------------------
  logic [7:0] pl, pwm_on, drive;
  wire p0 = cnt_q[0] < gr_q[1];
  wire pa1 = cnt_q[1] < gr_q[4];
  wire pb1 = cnt_q[1] < gr_q[5];
  // ch0 D lags by using counter 1, which starts the non-overlap behind
  assign pl = {comp ? ~pb1 : (cnt_q[1] < gr_q[7]), ~pa1, pb1, pa1,
               cnt_q[1] < gr_q[1], ~p0, p0, 1'b0};
  assign pwm_on = comp ? 8'hFE :
                  {pwmd_q && combo_q == dtb_pkg::COMBO_NORMAL, 7'h00};

  generate
    for (e = 0; e < 8; e++) begin : g_pin
      wire [2:0] iof = io_q[e/4][3*(e%4) +: 3];
      wire tout = ~iof[2] & (iof[1] | iof[0]);
      assign drive[e] = ~stby_q & ~outdis_q[e] &
                        (pwm_on[e] | tout |
                         combo_q != dtb_pkg::COMBO_NORMAL);
      // output control write presets; compare then sets, clears, toggles
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          lvl_q[e] <= dtb_pkg::RST_OUTCTL[e];
        end else if (wr_outctl && wstrb_q[0]) begin
          lvl_q[e] <= wdata_q[e];
        end else if (match_ev[e] && tout) begin
          lvl_q[e] <= iof[1] ? (iof[0] ? ~lvl_q[e] : 1'b1) : 1'b0;
        end
      end
    end
  endgenerate

  // pin flops; pin 7 falls back to the port when the timer lets go
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      outctl_q <= dtb_pkg::RST_OUTCTL;
      out_q <= 8'h00;
      oe_n_q <= 8'hFF;
    end else begin
      if (wr_outctl && wstrb_q[0]) outctl_q <= wdata_q[7:0];
      out_q <= (pwm_on & pl) | (~pwm_on & lvl_q);
      oe_n_q <= ~drive;
      if (!drive[7]) begin
        out_q[7] <= pdat_q;
        oe_n_q[7] <= ~pdir_q;
      end
    end
  end

  assign tio_out = out_q;
  assign tio_oe_n = oe_n_q;

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  wire [7:0] ra = s_axi_araddr;
  always_comb begin
    rd_err = 1'b0;
    rd_d = 32'h0;
    if (ra[1:0] != 2'b00) rd_err = 1'b1;
    else if (ra == dtb_pkg::OFS_MODE)
      rd_d = {24'h0, mode_buf_q, dtb_pkg::MODE_RSVD_ONES, sync_q};
    else if (ra == dtb_pkg::OFS_RUN) rd_d = {30'h0, run_q};
    else if (ra == dtb_pkg::OFS_FUNC) rd_d = {29'h0, pwmd_q, combo_q};
    else if (ra == dtb_pkg::OFS_OUTCTL) rd_d = {24'h0, outctl_q};
    else if (ra == dtb_pkg::OFS_OUTEN) rd_d = {24'h0, outdis_q};
    else if (ra == dtb_pkg::OFS_CTL0) rd_d = {25'h0, ctl_q[0]};
    else if (ra == dtb_pkg::OFS_CTL1) rd_d = {25'h0, ctl_q[1]};
    else if (ra == dtb_pkg::OFS_IO0) rd_d = {20'h0, io_q[0]};
    else if (ra == dtb_pkg::OFS_IO1) rd_d = {20'h0, io_q[1]};
    else if (ra == dtb_pkg::OFS_PORT)
      rd_d = {29'h0, filt_q[7], pdat_q, pdir_q};
    else if (ra == dtb_pkg::OFS_STBY) rd_d = {31'h0, stby_q};
    else if (ra == dtb_pkg::OFS_CNT0) rd_d = {16'h0, cnt_q[0]};
    else if (ra == dtb_pkg::OFS_CNT1) rd_d = {16'h0, cnt_q[1]};
    else if (ra >= dtb_pkg::OFS_GR && ra < dtb_pkg::OFS_GR_END)
      rd_d = {16'h0, gr_q[ra[4:2]]};
    else rd_err = 1'b1;
  end

endmodule

// *** dtb_pkg.sv ***
// shared constants for the dual timer with buffer and complementary pwm
package dtb_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_RUN = 8'h04;
  localparam logic [7:0] OFS_FUNC = 8'h08;
  localparam logic [7:0] OFS_OUTCTL = 8'h0C;
  localparam logic [7:0] OFS_OUTEN = 8'h10;
  localparam logic [7:0] OFS_CTL0 = 8'h14;
  localparam logic [7:0] OFS_CTL1 = 8'h18;
  localparam logic [7:0] OFS_IO0 = 8'h1C;
  localparam logic [7:0] OFS_IO1 = 8'h20;
  localparam logic [7:0] OFS_PORT = 8'h24;
  localparam logic [7:0] OFS_STBY = 8'h28;
  localparam logic [7:0] OFS_CNT0 = 8'h2C;
  localparam logic [7:0] OFS_CNT1 = 8'h30;
  localparam logic [7:0] OFS_GR = 8'h40;
  localparam logic [7:0] OFS_GR_END = 8'h60;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int MODE_SYNC_BIT = 0;
  localparam int MODE_BUF_LSB = 4;
  localparam logic [2:0] MODE_RSVD_ONES = 3'h7;
  localparam int CTL_PSC_LSB = 0;
  localparam int CTL_EDGE_LSB = 3;
  localparam int CTL_CLR_LSB = 5;
  localparam int FUNC_PWMD_BIT = 2;
  localparam logic [7:0] RST_OUTDIS = 8'hFF;
  localparam logic [7:0] RST_OUTCTL = 8'h00;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    COMBO_NORMAL = 2'b00,
    COMBO_RSVD = 2'b01,
    COMBO_RSYNC = 2'b10,
    COMBO_COMP = 2'b11
  } dtb_combo_e;
  typedef enum logic [1:0] {
    CLR_NONE = 2'b00,
    CLR_GRA = 2'b01,
    CLR_GRB = 2'b10,
    CLR_SYNC = 2'b11
  } dtb_clr_e;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** dtb_timer_checker.sv ***
// port-level assertions for the dual timer, bound to its top module
`timescale 1ns/100ps
module dtb_timer_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // timer pins
  input wire logic [7:0] tio_oe_n
);
  // ------------------------------------------------------------
  // address decode helpers
  // ------------------------------------------------------------
  function automatic logic bad_addr(input logic [7:0] a);
    return (a[1:0] != 2'h0) || (a >= dtb_pkg::OFS_GR_END) ||
      (a > dtb_pkg::OFS_CNT1 && a < dtb_pkg::OFS_GR);
  endfunction

  // transfers taken this edge; aw and w offered together by the master
  wire aw_take = s_axi_awvalid && s_axi_awready &&
                 s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire aw_bad = bad_addr(s_axi_awaddr);
  wire ar_bad = bad_addr(s_axi_araddr);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_release: assert property ($rose(aresetn) |->
    !s_axi_bvalid && !s_axi_rvalid && tio_oe_n == 8'hFF)
    else $error("bus or pins active out of reset");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped early");
  a_write_okay: assert property (aw_take && !aw_bad |=> ##1
    (s_axi_bvalid && s_axi_bresp == dtb_pkg::RESP_OKAY))
    else $error("mapped write not answered okay");
  a_write_error: assert property (aw_take && aw_bad |=> ##1
    (s_axi_bvalid && s_axi_bresp == dtb_pkg::RESP_SLVERR))
    else $error("unmapped write not refused");
  a_read_okay: assert property (ar_take && !ar_bad |=>
    s_axi_rvalid && s_axi_rresp == dtb_pkg::RESP_OKAY)
    else $error("mapped read not answered okay");
  a_read_error: assert property (ar_take && ar_bad |=>
    s_axi_rvalid && s_axi_rresp == dtb_pkg::RESP_SLVERR && s_axi_rdata == 0)
    else $error("unmapped read not refused");
  a_mode_ones: assert property (ar_take &&
    s_axi_araddr == dtb_pkg::OFS_MODE |=>
    s_axi_rdata[3:1] == dtb_pkg::MODE_RSVD_ONES)
    else $error("reserved mode bits not read as one");
  a_write_busy: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
endmodule

bind dtb_timer dtb_timer_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .tio_oe_n(tio_oe_n)
);

// *** dtb_pin_load.sv ***
// outside circuit on the timer pins
`timescale 1ns/100ps
module dtb_pin_load (
  // levels from the timer
  input wire logic [7:0] tio_out,
  input wire logic [7:0] tio_oe_n,
  // level the outside driver puts on released pins
  input wire logic [7:0] ext_level,
  // level seen back at the pins
  output logic [7:0] tio_in
);
  // released pins follow the outside driver, never the old timer level
  assign tio_in = (tio_out & ~tio_oe_n) | (ext_level & tio_oe_n);
endmodule

// *** dtb_timer_tb.sv ***
// self-checking bench for the dual timer through its register bus
`timescale 1ns/100ps
module dtb_timer_tb;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam logic [7:0] GA0 = dtb_pkg::OFS_GR;
  localparam logic [7:0] GB0 = dtb_pkg::OFS_GR + 8'h04;
  localparam logic [7:0] GC0 = dtb_pkg::OFS_GR + 8'h08;
  localparam logic [7:0] GD0 = dtb_pkg::OFS_GR + 8'h0C;
  localparam logic [7:0] GA1 = dtb_pkg::OFS_GR + 8'h10;
  localparam logic [7:0] GB1 = dtb_pkg::OFS_GR + 8'h14;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, ext_level = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, ext_clk = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, v, w;
  logic [7:0] tio_in, tio_out, tio_oe_n;
  int n_errors = 0;
  int checks_done = 0;

  always #12.5 aclk = ~aclk;

  dtb_timer uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .tio_in(tio_in), .tio_out(tio_out),
    .tio_oe_n(tio_oe_n), .ext_clk_in(ext_clk)
  );
  dtb_pin_load u_load (.tio_out(tio_out), .tio_oe_n(tio_oe_n),
    .ext_level(ext_level), .tio_in(tio_in));

  // ------------------------------------------------------------
  // bus tasks and comparison
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    if (n_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      aw_done = aw_done || awready;
      w_done = w_done || wready;
    end
    // ready raised late on purpose, so the slave must hold its answer
    while (!bvalid)
      @(posedge aclk);
    bready <= 1'b1;
    @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    @(posedge aclk);
    while (!arready)
      @(posedge aclk);
    arvalid <= 1'b0;
    while (!rvalid)
      @(posedge aclk);
    rready <= 1'b1;
    @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, v);
    chk(v, e);
  endtask

  // ------------------------------------------------------------
  // watchdog, far above the several hundred cycles the run needs
  // ------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    give_verdict();
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(dtb_pkg::OFS_MODE, 32'h0E);
    rchk(dtb_pkg::OFS_OUTEN, 32'hFF);
    wr(dtb_pkg::OFS_MODE, 32'hFF);
    rchk(dtb_pkg::OFS_MODE, 32'hFF);
    wr(dtb_pkg::OFS_MODE, 32'h00);
    rchk(dtb_pkg::OFS_MODE, 32'h0E);
    // counter sync on, then off
    wr(dtb_pkg::OFS_MODE, 32'h01);
    wr(dtb_pkg::OFS_CNT0, 32'h1234);
    rchk(dtb_pkg::OFS_CNT1, 32'h1234);
    wr(dtb_pkg::OFS_MODE, 32'h00);
    wr(dtb_pkg::OFS_CNT0, 32'h0055);
    rchk(dtb_pkg::OFS_CNT1, 32'h1234);
    // hole in the map is refused both ways
    wr(8'h34, 32'h1);
    chk(r, dtb_pkg::RESP_SLVERR);
    rchk(8'h34, 32'h0);
    chk(r, dtb_pkg::RESP_SLVERR);
    // compare with buffering on A/C and B/D of channel 0
    wr(dtb_pkg::OFS_MODE, 32'h30);
    wr(GA0, 32'h10);
    wr(GC0, 32'h20);
    wr(GB0, 32'h08);
    wr(GD0, 32'h30);
    wr(dtb_pkg::OFS_IO0, 32'h12);
    wr(dtb_pkg::OFS_OUTEN, 32'hFC);
    wr(dtb_pkg::OFS_CNT0, 32'h0);
    wr(dtb_pkg::OFS_RUN, 32'h1);
    repeat (80) @(posedge aclk);
    wr(dtb_pkg::OFS_RUN, 32'h0);
    rchk(GA0, 32'h20);
    rchk(GB0, 32'h30);
    chk(tio_out[1:0], 2'b11);
    chk(tio_oe_n[2:0], 3'b100);
    // capture with buffering, counter held by a silent external clock
    wr(dtb_pkg::OFS_CTL0, 32'h04);
    wr(dtb_pkg::OFS_CNT0, 32'h0ABC);
    wr(GA0, 32'h1111);
    wr(dtb_pkg::OFS_IO0, 32'h4);
    wr(dtb_pkg::OFS_RUN, 32'h1);
    ext_level[0] <= 1'b1;
    repeat (10) @(posedge aclk);
    rchk(GA0, 32'h0ABC);
    rchk(GC0, 32'h1111);
    // complementary pwm set up in order
    wr(dtb_pkg::OFS_RUN, 32'h0);
    wr(dtb_pkg::OFS_MODE, 32'h00);
    wr(dtb_pkg::OFS_OUTCTL, 32'h00);
    wr(dtb_pkg::OFS_CTL0, 32'h00);
    wr(dtb_pkg::OFS_CTL1, 32'h00);
    wr(dtb_pkg::OFS_IO0, 32'h0);
    wr(dtb_pkg::OFS_FUNC, 32'h3);
    wr(dtb_pkg::OFS_CNT1, 32'h0);
    wr(dtb_pkg::OFS_CNT0, 32'h2);
    wr(GA0, 32'h40);
    wr(GB0, 32'h10);
    wr(GA1, 32'h20);
    wr(GB1, 32'h30);
    wr(dtb_pkg::OFS_OUTEN, 32'h00);
    wr(dtb_pkg::OFS_RUN, 32'h3);
    for (int i = 0; i < 8; i++) begin
      repeat (7) @(posedge aclk);
      chk(tio_oe_n[7:1], 7'h00);
      chk(tio_out[2], !tio_out[1]);
      chk(tio_out[7], !tio_out[5]);
    end
    wr(dtb_pkg::OFS_FUNC, 32'h0);
    wr(dtb_pkg::OFS_RUN, 32'h0);
    // standby stops the counter and frees the pins
    wr(dtb_pkg::OFS_IO0, 32'h2);
    wr(GA0, 32'h5);
    wr(dtb_pkg::OFS_CNT0, 32'h0);
    wr(dtb_pkg::OFS_OUTEN, 32'hFE);
    wr(dtb_pkg::OFS_RUN, 32'h1);
    repeat (20) @(posedge aclk);
    chk(tio_oe_n[0], 1'b0);
    wr(dtb_pkg::OFS_STBY, 32'h1);
    repeat (6) @(posedge aclk);
    chk(tio_oe_n[0], 1'b1);
    rd(dtb_pkg::OFS_CNT0, v);
    rd(dtb_pkg::OFS_CNT0, w);
    chk(w, v);
    wr(dtb_pkg::OFS_STBY, 32'h0);
    wr(dtb_pkg::OFS_RUN, 32'h0);
    // shared pin as port output, port input, then timer output
    wr(dtb_pkg::OFS_PORT, 32'h3);
    repeat (2) @(posedge aclk);
    chk({tio_oe_n[7], tio_out[7]}, 2'b01);
    wr(dtb_pkg::OFS_PORT, 32'h0);
    ext_level[7] <= 1'b1;
    repeat (8) @(posedge aclk);
    rchk(dtb_pkg::OFS_PORT, 32'h4);
    chk(tio_oe_n[7], 1'b1);
    wr(dtb_pkg::OFS_OUTEN, 32'h7F);
    wr(dtb_pkg::OFS_IO1, 32'h200);
    repeat (2) @(posedge aclk);
    chk(tio_oe_n[7], 1'b0);
    give_verdict();
  end
endmodule
